// File: rtl/eemr_device.sv
// Behaviour
// - smi bit5: hub a unimplemented cycle
// - smi bit4: agp access outside aperture
// - smi bit3: invalid agp access region
// - smi bit2: invalid translation entry
// - smi bit1: multibit ecc; software clears
// - smi bit0: single-bit ecc; software clears
// - sci enable at ce, reset zero
// - one message per error event
// - software keeps other reports disabled
// - sci bit12: host bus/internal error
// - sci bit11: corrected host data error
// - sci bit10: thermal trip edge
// - sci bit9: lock to non-dram
// - sci bit8: hub b target abort
// - sci bit7: hub b unimplemented cycle
// - sci bit6: hub a target abort
// - sci bit5: hub a unimplemented cycle
// - smi enable at cc, reset zero
// - smi bit6: hub a target abort
`timescale 1ns/1ps
module eemr_device (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [15:0] cfg_wdata_i,
  output logic [15:0] cfg_rdata_o,
  // detected conditions, one-cycle pulses
  input wire logic singlebit_ecc_i,
  input wire logic multibit_ecc_i,
  input wire logic bad_translation_i,
  input wire logic invalid_agp_i,
  input wire logic outside_aperture_i,
  input wire logic hub_a_unimpl_i,
  input wire logic hub_a_abort_i,
  input wire logic hub_b_unimpl_i,
  input wire logic hub_b_abort_i,
  input wire logic lock_non_dram_i,
  input wire logic mem_over_temp_i,
  input wire logic host_correctable_i,
  // pins
  input wire logic over_temp_input_n_i,
  input wire logic host_bus_error_n_i,
  input wire logic host_internal_error_n_i,
  // hub link a
  eemr_link_if.device link
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] smi_en_reg;
  logic [15:0] sci_en_reg;
  logic [15:0] rdata_reg;
  logic [2:0] ot_sync_reg;
  logic [2:0] be_sync_reg;
  logic [2:0] ie_sync_reg;
  logic [eemr_pkg::NUM_COND-1:0] pend_smi_reg;
  logic [eemr_pkg::NUM_COND-1:0] pend_sci_reg;
  eemr_pkg::eemr_msg_t kind_reg;
  logic [eemr_pkg::SRC_W-1:0] src_reg;

  typedef enum logic {
    EEMR_IDLE,
    EEMR_SEND
  } eemr_state_t;
  eemr_state_t state_reg;

  logic [eemr_pkg::NUM_COND-1:0] event_vec;
  logic [eemr_pkg::NUM_COND-1:0] smi_set;
  logic [eemr_pkg::NUM_COND-1:0] sci_set;
  logic [eemr_pkg::NUM_COND-1:0] smi_clr;
  logic [eemr_pkg::NUM_COND-1:0] sci_clr;
  logic pick_any;
  eemr_pkg::eemr_msg_t pick_kind;
  logic [eemr_pkg::SRC_W-1:0] pick_src;
  logic [15:0] wmask;
  logic load;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  assign wmask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smi_en_reg <= eemr_pkg::SMI_EN_RESET;
    end else if (cfg_wr_i && cfg_addr_i == eemr_pkg::SMI_EN_OFFSET) begin
      smi_en_reg <= (smi_en_reg & ~wmask)
        | (cfg_wdata_i & wmask & eemr_pkg::SMI_EN_MASK);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sci_en_reg <= eemr_pkg::SCI_EN_RESET;
    end else if (cfg_wr_i && cfg_addr_i == eemr_pkg::SCI_EN_OFFSET) begin
      sci_en_reg <= (sci_en_reg & ~wmask)
        | (cfg_wdata_i & wmask & eemr_pkg::SCI_EN_MASK);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (cfg_rd_i) begin
      case (cfg_addr_i)
        eemr_pkg::SMI_EN_OFFSET: rdata_reg <= smi_en_reg;
        eemr_pkg::SCI_EN_OFFSET: rdata_reg <= sci_en_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign cfg_rdata_o = rdata_reg;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ot_sync_reg <= 3'h7;
      be_sync_reg <= 3'h7;
      ie_sync_reg <= 3'h7;
    end else begin
      ot_sync_reg <= {ot_sync_reg[1:0], over_temp_input_n_i};
      be_sync_reg <= {be_sync_reg[1:0], host_bus_error_n_i};
      ie_sync_reg <= {ie_sync_reg[1:0], host_internal_error_n_i};
    end
  end

  // ----------------------------------------
  // condition vector
  // ----------------------------------------
  always_comb begin
    event_vec = '0;
    event_vec[eemr_pkg::COND_SINGLEBIT_ECC] = singlebit_ecc_i;
    event_vec[eemr_pkg::COND_MULTIBIT_ECC] = multibit_ecc_i;
    event_vec[eemr_pkg::COND_BAD_TRANSLATION] = bad_translation_i;
    event_vec[eemr_pkg::COND_INVALID_AGP] = invalid_agp_i;
    event_vec[eemr_pkg::COND_OUTSIDE_APERTURE] = outside_aperture_i;
    event_vec[eemr_pkg::COND_HUB_A_UNIMPL] = hub_a_unimpl_i;
    event_vec[eemr_pkg::COND_HUB_A_ABORT] = hub_a_abort_i;
    event_vec[eemr_pkg::COND_HUB_B_UNIMPL] = hub_b_unimpl_i;
    event_vec[eemr_pkg::COND_HUB_B_ABORT] = hub_b_abort_i;
    event_vec[eemr_pkg::COND_LOCK_NON_DRAM] = lock_non_dram_i;
    event_vec[eemr_pkg::COND_THERMAL] = mem_over_temp_i
      | (ot_sync_reg[1] & ~ot_sync_reg[2]);
    event_vec[eemr_pkg::COND_HOST_CORRECTABLE] = host_correctable_i;
    event_vec[eemr_pkg::COND_HOST_UNCORRECT] =
      (be_sync_reg[2] & ~be_sync_reg[1])
      | (ie_sync_reg[2] & ~ie_sync_reg[1]);
  end

  // smi wins if software enabled both, so one message per event
  assign smi_set = event_vec & smi_en_reg[eemr_pkg::NUM_COND-1:0];
  assign sci_set = event_vec & sci_en_reg[eemr_pkg::NUM_COND-1:0]
    & ~smi_en_reg[eemr_pkg::NUM_COND-1:0];

  // ----------------------------------------
  // arbiter: smi first, lowest condition first
  // ----------------------------------------
  always_comb begin
    pick_any = 1'h0;
    pick_kind = eemr_pkg::EEMR_MSG_SMI;
    pick_src = '0;
    smi_clr = '0;
    sci_clr = '0;
    for (int i = eemr_pkg::NUM_COND - 1; i >= 0; i--) begin
      if (pend_sci_reg[i]) begin
        pick_any = 1'h1;
        pick_kind = eemr_pkg::EEMR_MSG_SCI;
        pick_src = eemr_pkg::SRC_W'(i);
      end
    end
    for (int i = eemr_pkg::NUM_COND - 1; i >= 0; i--) begin
      if (pend_smi_reg[i]) begin
        pick_any = 1'h1;
        pick_kind = eemr_pkg::EEMR_MSG_SMI;
        pick_src = eemr_pkg::SRC_W'(i);
      end
    end
    if (load && pick_kind == eemr_pkg::EEMR_MSG_SMI) begin
      smi_clr[pick_src] = 1'h1;
    end
    if (load && pick_kind == eemr_pkg::EEMR_MSG_SCI) begin
      sci_clr[pick_src] = 1'h1;
    end
  end

  assign load = (state_reg == EEMR_IDLE) && pick_any;

  // pending: a new event in the clearing cycle stays pending
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_smi_reg <= '0;
      pend_sci_reg <= '0;
    end else begin
      pend_smi_reg <= (pend_smi_reg & ~smi_clr) | smi_set;
      pend_sci_reg <= (pend_sci_reg & ~sci_clr) | sci_set;
    end
  end

  // ----------------------------------------
  // sender
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= EEMR_IDLE;
    end else begin
      case (state_reg)
        EEMR_IDLE: begin
          if (pick_any) begin
            state_reg <= EEMR_SEND;
          end
        end
        EEMR_SEND: begin
          if (link.msg_ready) begin
            state_reg <= EEMR_IDLE;
          end
        end
        default: state_reg <= EEMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      kind_reg <= eemr_pkg::EEMR_MSG_SMI;
      src_reg <= '0;
    end else if (load) begin
      kind_reg <= pick_kind;
      src_reg <= pick_src;
    end
  end

  assign link.msg_valid = (state_reg == EEMR_SEND);
  assign link.msg_kind = kind_reg;
  assign link.msg_src = src_reg;

endmodule // eemr_device

// File: rtl/eemr_pkg.sv
package eemr_pkg;
  // ----------------------------------------
  // configuration map
  // ----------------------------------------
  localparam logic [7:0] SMI_EN_OFFSET = 8'hcc;
  localparam logic [7:0] SCI_EN_OFFSET = 8'hce;
  localparam logic [15:0] SMI_EN_RESET = 16'h0000;
  localparam logic [15:0] SCI_EN_RESET = 16'h0000;
  // writable bits; reserved bits read zero
  localparam logic [15:0] SMI_EN_MASK = 16'h0dff;
  localparam logic [15:0] SCI_EN_MASK = 16'h1fff;
  // ----------------------------------------
  // condition positions, shared by both enables
  // ----------------------------------------
  localparam int COND_SINGLEBIT_ECC = 0;
  localparam int COND_MULTIBIT_ECC = 1;
  localparam int COND_BAD_TRANSLATION = 2;
  localparam int COND_INVALID_AGP = 3;
  localparam int COND_OUTSIDE_APERTURE = 4;
  localparam int COND_HUB_A_UNIMPL = 5;
  localparam int COND_HUB_A_ABORT = 6;
  localparam int COND_HUB_B_UNIMPL = 7;
  localparam int COND_HUB_B_ABORT = 8;
  localparam int COND_LOCK_NON_DRAM = 9;
  localparam int COND_THERMAL = 10;
  localparam int COND_HOST_CORRECTABLE = 11;
  localparam int COND_HOST_UNCORRECT = 12;
  localparam int NUM_COND = 13;
  localparam int SRC_W = 4;
  // ----------------------------------------
  // message kinds on hub link a
  // ----------------------------------------
  typedef enum logic {
    EEMR_MSG_SMI,
    EEMR_MSG_SCI
  } eemr_msg_t;
endpackage

// File: rtl/eemr_link_if.sv
`timescale 1ns/1ps
interface eemr_link_if;
  logic msg_valid;
  logic msg_ready;
  eemr_pkg::eemr_msg_t msg_kind;
  logic [eemr_pkg::SRC_W-1:0] msg_src;

  modport device (
    output msg_valid,
    output msg_kind,
    output msg_src,
    input msg_ready
  );

  modport hub (
    input msg_valid,
    input msg_kind,
    input msg_src,
    output msg_ready
  );
endinterface

// File: rtl/eemr_hub.sv
`timescale 1ns/1ps
module eemr_hub (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // hub link a
  eemr_link_if.hub link,
  // user side
  input wire logic accept_i,
  output logic smi_o,
  output logic sci_o,
  output logic [eemr_pkg::SRC_W-1:0] src_o
);

  // ----------------------------------------
  // receive
  // ----------------------------------------
  logic smi_reg;
  logic sci_reg;
  logic [eemr_pkg::SRC_W-1:0] src_reg;
  logic take;

  assign link.msg_ready = accept_i;
  assign take = link.msg_valid && accept_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smi_reg <= 1'h0;
      sci_reg <= 1'h0;
    end else begin
      smi_reg <= take && link.msg_kind == eemr_pkg::EEMR_MSG_SMI;
      sci_reg <= take && link.msg_kind == eemr_pkg::EEMR_MSG_SCI;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg <= '0;
    end else if (take) begin
      src_reg <= link.msg_src;
    end
  end

  assign smi_o = smi_reg;
  assign sci_o = sci_reg;
  assign src_o = src_reg;

endmodule // eemr_hub

// File: sim/eemr_chk.sv
`timescale 1ns/1ps
module eemr_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // hub link a
  input wire logic msg_valid,
  input wire logic msg_ready,
  input wire eemr_pkg::eemr_msg_t msg_kind,
  input wire logic [eemr_pkg::SRC_W-1:0] msg_src
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] up_reg;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  end
  sequence stall_s;
    msg_valid && !msg_ready;
  endsequence
  sequence hs_s;
    msg_valid && msg_ready;
  endsequence
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  valid_hold_a: assert property (stall_s |=> msg_valid)
    else $error("valid dropped while stalled");
  kind_hold_a: assert property (stall_s |=> $stable(msg_kind))
    else $error("kind changed while stalled");
  src_hold_a: assert property (stall_s |=> $stable(msg_src))
    else $error("source changed while stalled");
  gap_after_a: assert property (hs_s |=> !msg_valid)
    else $error("no idle cycle after handshake");
  drop_only_a: assert property ($fell(msg_valid) |-> $past(msg_ready))
    else $error("message withdrawn unaccepted");
  src_range_a: assert property (msg_valid |-> msg_src < 4'hd)
    else $error("source out of range");
  smi_src_a: assert property (msg_valid && msg_kind == eemr_pkg::EEMR_MSG_SMI
    |-> msg_src != 4'h9 && msg_src != 4'hc)
    else $error("smi from reserved source");
  idle_reset_a: assert property (up_reg < 2'h2 |-> !msg_valid)
    else $error("message right after reset");
endmodule // eemr_chk

// File: sim/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin fails++; \
  $display("FAIL %s exp %0h got %0h", n, e, g); end end
module testbench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk_i, rst_n_i, cfg_wr, cfg_rd, accept, ot_n, host_bus_error_n_n, smi, sci;
  logic host_internal_error_n_n;
  logic [1:0] be;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [11:0] cond;
  logic [3:0] src;
  logic [5:0] q[$];
  logic [5:0] qx[4] = '{6'h10, 6'h14, 6'h16, 6'h29};
  int fails, check_count;
  eemr_link_if lnk ();
  eemr_device i_eemr_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr),
    .cfg_be_i(be), .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata),
    .singlebit_ecc_i(cond[0]), .multibit_ecc_i(cond[1]),
    .bad_translation_i(cond[2]), .invalid_agp_i(cond[3]),
    .outside_aperture_i(cond[4]), .hub_a_unimpl_i(cond[5]),
    .hub_a_abort_i(cond[6]), .hub_b_unimpl_i(cond[7]),
    .hub_b_abort_i(cond[8]), .lock_non_dram_i(cond[9]),
    .mem_over_temp_i(cond[10]), .host_correctable_i(cond[11]),
    .over_temp_input_n_i(ot_n), .host_bus_error_n_i(host_bus_error_n_n),
    .host_internal_error_n_i(host_internal_error_n_n), .link(lnk));
  eemr_hub i_eemr_hub (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk),
    .accept_i(accept), .smi_o(smi), .sci_o(sci), .src_o(src));
  eemr_chk i_eemr_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .msg_valid(lnk.msg_valid), .msg_ready(lnk.msg_ready),
    .msg_kind(lnk.msg_kind), .msg_src(lnk.msg_src));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(negedge clk_i) if (smi === 1'b1 || sci === 1'b1)
    q.push_back({sci, smi, src});
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_i);
    cfg_rd <= 1'b0;
    #1;
    `CHK("cfg_rdata", e, cfg_rdata)
  endtask
  task automatic waitq(input int n);
    for (int i = 0; i < 30 && q.size() < n; i++) @(posedge clk_i);
    if (q.size() < n) begin
      fails++;
      wrap_up();
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic ev(input int b, input int k);
    q.delete();
    @(posedge clk_i);
    if (b == 13) ot_n <= 1'b1;
    else if (b == 12) host_bus_error_n_n <= 1'b0;
    else if (b == 14) host_internal_error_n_n <= 1'b0;
    else cond[b] <= 1'b1;
    @(posedge clk_i);
    cond <= 12'h000;
    host_bus_error_n_n <= 1'b1;
    host_internal_error_n_n <= 1'b1;
    waitq(k != 0);
    `CHK("msg_count", k != 0, q.size())
    if (k != 0)
      `CHK("msg", {k == 2, k == 1,
        b == 13 ? 4'ha : b == 14 ? 4'hc : 4'(b)}, q[0])
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata, cond} = '0;
    {accept, ot_n, host_bus_error_n_n, host_internal_error_n_n} = 4'hf;
    be = 2'h3;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'hcc, 16'h0000);
    rd(8'hce, 16'h0000);
    wr(8'hcc, 16'hffff);
    wr(8'hce, 16'hffff);
    wr(8'h40, 16'hffff);
    rd(8'hcc, eemr_pkg::SMI_EN_MASK);
    rd(8'hce, eemr_pkg::SCI_EN_MASK);
    rd(8'h40, 16'h0000);
    ev(1, 1);
    wr(8'hce, 16'h0000);
    for (int b = 0; b < 12; b++) if (b != 9) ev(b, 1);
    wr(8'hcc, 16'h0000);
    ev(5, 0);
    wr(8'hce, 16'h1fff);
    for (int b = 0; b < 13; b++) ev(b, 2);
    q.delete();
    ot_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK("falling_temp", 0, q.size())
    ev(13, 2);
    ev(14, 2);
    wr(8'hcc, 16'h0dff);
    accept <= 1'b0;
    q.delete();
    @(posedge clk_i);
    cond <= 12'h251;
    @(posedge clk_i);
    cond <= 12'h000;
    repeat (6) @(posedge clk_i);
    accept <= 1'b1;
    waitq(4);
    for (int i = 0; i < 4; i++) `CHK("queued", qx[i], q[i])
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(8'hcc, 16'h0000);
    @(posedge clk_i);
    be <= 2'h1;
    wr(8'hce, 16'hffff);
    rd(8'hce, 16'h00ff);
    @(posedge clk_i);
    be <= 2'h2;
    wr(8'hcc, 16'hffff);
    rd(8'hcc, 16'h0d00);
    wrap_up();
  end
endmodule // testbench
